//--- hdl/sai_pkg.sv
// package for the serial audio input port: register map, fields, timing
package sai_pkg;

	// ****************************************
	// register offsets and reset values
	// ****************************************
	localparam logic [7:0] SAI_ADDR_FORMAT = 8'h33;
	localparam logic [7:0] SAI_ADDR_OFFSET = 8'h34;
	localparam logic [7:0] SAI_ADDR_STATUS = 8'h71;
	localparam logic [7:0] SAI_FORMAT_RST  = 8'h02;
	localparam logic [7:0] SAI_OFFSET_RST  = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int SAI_FMT_LSB  = 4;
	localparam int SAI_SHORT_LSB = 2;
	localparam int SAI_WLEN_LSB = 0;
	localparam int SAI_OFSH_LSB = 6;
	localparam int SAI_ST_HALT  = 0;
	localparam int SAI_ST_RATIO = 1;

	// ****************************************
	// timing
	// ****************************************
	localparam int SAI_CLK_HZ      = 10_000_000;
	localparam int SAI_HALT_US     = 100;
	localparam int SAI_HALT_CYC    = SAI_HALT_US * (SAI_CLK_HZ / 1_000_000);
	localparam int SAI_RATE32_NUM  = 28;
	localparam int SAI_RATE48_NUM  = 40;
	localparam int SAI_VALID_FR    = 2;

	typedef enum logic [1:0] {
		SAI_FMT_I2S = 2'b00,
		SAI_FMT_LEFT_JUSTIFIED  = 2'b01,
		SAI_FMT_RIGHT_JUSTIFIED = 2'b10,
		SAI_FMT_TDM = 2'b11
	} sai_fmt_e;

	typedef enum logic [1:0] {
		SAI_WL_16 = 2'b00,
		SAI_WL_20 = 2'b01,
		SAI_WL_24 = 2'b10,
		SAI_WL_32 = 2'b11
	} sai_wlen_e;

	typedef enum logic [1:0] {
		SAI_RATE_32 = 2'b00,
		SAI_RATE_48 = 2'b01,
		SAI_RATE_96 = 2'b10
	} sai_rate_e;

	typedef enum logic [1:0] {
		SAI_ST_IDLE = 2'b00,
		SAI_ST_RUN  = 2'b01,
		SAI_ST_HIZ  = 2'b10
	} sai_state_e;

	typedef struct packed {
		logic [31:0] left;
		logic [31:0] right;
	} sai_sample_s;

	typedef struct packed {
		logic       lock;
		sai_rate_e  rate;
		logic [1:0] dsp_div;
	} sai_clkcfg_s;

endpackage

//--- hdl/sai_port.sv
// serial audio input port: framing, rate detect, clock fault handling
// ****************************************
// ****************************************
`timescale 1ns/1ps
module sai_port
	import sai_pkg::*;
#(
	parameter int HALT_CYC = SAI_HALT_CYC
) (
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               rstn,
	// serial link
	input  wire logic               bit_clock,
	input  wire logic               word_select_frame_sync,
	input  wire logic               serial_data_input,
	// register port
	input  wire logic [7:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	output logic [7:0]              reg_rdata,
	// audio and clocking out
	output sai_pkg::sai_sample_s    sample,
	output logic                    sample_valid,
	output sai_pkg::sai_clkcfg_s    clk_cfg,
	output logic                    dsp_clk_en,
	output logic                    out_enable
);
	import sai_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] audio_format_control;
	logic [7:0] tdm_slot_offset;
	logic [7:0] clock_fault_status;

	wire        wr_fmt = reg_wr && (reg_addr == SAI_ADDR_FORMAT);
	wire        wr_ofs = reg_wr && (reg_addr == SAI_ADDR_OFFSET);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			audio_format_control <= SAI_FORMAT_RST;
			tdm_slot_offset      <= SAI_OFFSET_RST;
		end else begin
			if (wr_fmt) begin
				audio_format_control <= reg_wdata;
			end
			if (wr_ofs) begin
				tdm_slot_offset <= reg_wdata;
			end
		end
	end

	always_comb begin
		unique case (reg_addr)
			SAI_ADDR_FORMAT: reg_rdata = audio_format_control;
			SAI_ADDR_OFFSET: reg_rdata = tdm_slot_offset;
			SAI_ADDR_STATUS: reg_rdata = clock_fault_status;
			default:         reg_rdata = 8'h00;
		endcase
	end

	wire sai_fmt_e  fmt   = sai_fmt_e'(audio_format_control[SAI_FMT_LSB +: 2]);
	wire sai_wlen_e wlen  = sai_wlen_e'(audio_format_control[SAI_WLEN_LSB +: 2]);
	wire [9:0]      ofs   = {audio_format_control[SAI_OFSH_LSB +: 2], tdm_slot_offset};

	function automatic logic [5:0] wlen_bits(input sai_wlen_e w);
		unique case (w)
			SAI_WL_16: wlen_bits = 6'd16;
			SAI_WL_20: wlen_bits = 6'd20;
			SAI_WL_24: wlen_bits = 6'd24;
			SAI_WL_32: wlen_bits = 6'd32;
		endcase
	endfunction

	wire [5:0] nbits = wlen_bits(wlen);

	// ****************************************
	// pin synchronisers and edge detect
	// ****************************************
	logic [1:0] sck_s, ws_s, sd_s;
	logic       sck_d;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sck_s <= 2'b00;
			ws_s  <= 2'b00;
			sd_s  <= 2'b00;
			sck_d <= 1'b0;
		end else begin
			sck_s <= {sck_s[0], bit_clock};
			ws_s  <= {ws_s[0], word_select_frame_sync};
			sd_s  <= {sd_s[0], serial_data_input};
			sck_d <= sck_s[1];
		end
	end

	wire sck_rise = sck_s[1] && !sck_d;
	wire ws_now   = ws_s[1];
	wire sd_now   = sd_s[1];

	// ****************************************
	// bit counting within frame / half frame
	// ****************************************
	// ws is sampled on each bit clock rising edge, so both word select
	// phases and the tdm sync edge are seen from the same reference
	logic        ws_bit;
	logic [9:0]  bitcnt;
	logic [9:0]  frame_len;
	logic [63:0] shreg;
	logic        word_left;
	wire         tdm = (fmt == SAI_FMT_TDM);
	wire         ws_chg  = ws_now != ws_bit;
	wire         tdm_st  = tdm && ws_now && !ws_bit;
	wire         half_st = !tdm && ws_chg;
	wire         start   = tdm ? tdm_st : (half_st && !ws_now);
	// i2s: left while ws low; justified modes: left while ws high
	wire         left_ph = (fmt == SAI_FMT_I2S) ? !ws_now : ws_now;
	wire [9:0]   lead    = (fmt == SAI_FMT_I2S) ? 10'd1 : 10'd0;
	wire [9:0]   cnt_nx  = (tdm ? tdm_st : half_st) ? 10'd0 : bitcnt + 10'd1;
	wire [9:0]   tdm_ofs = ofs;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ws_bit    <= 1'b0;
			bitcnt    <= 10'd0;
			frame_len <= 10'd0;
			shreg     <= 64'h0000_0000_0000_0000;
		end else if (sck_rise) begin
			ws_bit <= ws_now;
			bitcnt <= cnt_nx;
			shreg  <= {shreg[62:0], sd_now};
			if (start) begin
				frame_len <= tdm ? bitcnt + 10'd1 : (bitcnt + 10'd1) << 1;
			end
		end
	end

	// capture point: last bit of the word in the current half or slot
	wire [9:0] half_len = frame_len >> 1;
	wire [9:0] msb_pos  = tdm ? tdm_ofs :
		((fmt == SAI_FMT_RIGHT_JUSTIFIED) ? half_len - 10'(nbits) : lead);
	wire [9:0] cnt_now  = cnt_nx;
	wire       cap_hit  = sck_rise && (cnt_now == msb_pos + 10'(nbits) - 10'd1);

	// msb first: the word now sits in the low nbits of the shift register
	function automatic logic [31:0] align(input logic [63:0] s, input logic [5:0] n);
		align = 32'(s[31:0] << (6'd32 - n));
	endfunction

	wire [31:0] new_word = align({shreg[62:0], sd_now}, nbits);
	wire        is_left  = tdm ? 1'b1 : left_ph;

	// ****************************************
	// rate detection and clock ratio check
	// ****************************************
	logic [15:0] per_cnt;
	logic [15:0] frame_per;
	logic [1:0]  good_fr;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			per_cnt   <= 16'h0000;
			frame_per <= 16'h0000;
		end else if (sck_rise && start) begin
			frame_per <= per_cnt;
			per_cnt   <= 16'h0000;
		end else if (per_cnt != 16'hFFFF) begin
			per_cnt <= per_cnt + 16'h0001;
		end
	end

	// frame period in system clocks: 32k ~ 312, 48k ~ 208, 96k ~ 104
	wire [15:0] lim32 = 16'(SAI_RATE32_NUM * 10);
	wire [15:0] lim48 = 16'(SAI_RATE48_NUM * 4);
	wire sai_rate_e rate_det = (frame_per > lim32) ? SAI_RATE_32 :
		(frame_per > lim48) ? SAI_RATE_48 : SAI_RATE_96;

	function automatic logic ratio_ok(input logic t, input logic [9:0] n, input sai_rate_e r);
		if (!t) begin
			ratio_ok = (n == 10'd32) || (n == 10'd64);
		end else begin
			unique case (r)
				SAI_RATE_32: ratio_ok = (n == 10'd128);
				SAI_RATE_48: ratio_ok = (n == 10'd128) || (n == 10'd256) || (n == 10'd512);
				default:     ratio_ok = (n == 10'd128) || (n == 10'd256);
			endcase
		end
	endfunction

	wire ratio_good = ratio_ok(tdm, frame_len, rate_det);

	// ****************************************
	// halt watchdog and run state
	// ****************************************
	logic [15:0] halt_cnt;
	sai_state_e  state;
	wire         halted = (halt_cnt >= 16'(HALT_CYC));

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			halt_cnt <= 16'h0000;
		end else if (sck_rise) begin
			halt_cnt <= 16'h0000;
		end else if (!halted) begin
			halt_cnt <= halt_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state   <= SAI_ST_IDLE;
			good_fr <= 2'b00;
		end else begin
			unique case (state)
				SAI_ST_IDLE,
				SAI_ST_HIZ: begin
					if (halted || !ratio_good) begin
						good_fr <= 2'b00;
					end else if (sck_rise && start && good_fr != 2'(SAI_VALID_FR)) begin
						good_fr <= good_fr + 2'b01;
					end
					if (good_fr == 2'(SAI_VALID_FR)) begin
						state <= SAI_ST_RUN;
					end
				end
				SAI_ST_RUN: begin
					good_fr <= 2'b00;
					if (halted) begin
						state <= SAI_ST_HIZ;
					end
				end
				default: state <= SAI_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			clock_fault_status <= 8'h00;
		end else begin
			clock_fault_status[SAI_ST_HALT]  <= halted;
			clock_fault_status[SAI_ST_RATIO] <= !halted && frame_len != 10'd0 && !ratio_good;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// dsp clock enable: one pulse every div+1 system clocks while running, div set by the
	// detected rate; stands in for the pll; no master clock is needed
	wire [1:0] div = (rate_det == SAI_RATE_96) ? 2'd0 : (rate_det == SAI_RATE_48) ? 2'd1 : 2'd2;
	logic [1:0] div_cnt;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			div_cnt    <= 2'd0;
			dsp_clk_en <= 1'b0;
			clk_cfg    <= '0;
			out_enable <= 1'b0;
		end else begin
			div_cnt    <= (div_cnt >= div) ? 2'd0 : div_cnt + 2'd1;
			dsp_clk_en <= (state == SAI_ST_RUN) && (div_cnt == 2'd0);
			clk_cfg    <= '{lock: state == SAI_ST_RUN, rate: rate_det, dsp_div: div};
			out_enable <= (state == SAI_ST_RUN);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sample       <= '0;
			sample_valid <= 1'b0;
		end else begin
			sample_valid <= 1'b0;
			if (cap_hit && state == SAI_ST_RUN) begin
				if (is_left) begin
					sample.left <= new_word;
				end else begin
					sample.right <= new_word;
					sample_valid <= 1'b1;
				end
				if (tdm && cnt_now == tdm_ofs + 10'(nbits) + 10'(nbits) - 10'd1) begin
					sample_valid <= 1'b1;
				end
			end
			if (tdm && state == SAI_ST_RUN && sck_rise &&
				cnt_now == tdm_ofs + 10'(nbits) + 10'(nbits) - 10'd1) begin
				sample.right <= new_word;
				sample_valid <= 1'b1;
			end
		end
	end

endmodule

//--- verif/sai_host_model.sv
// host model driving serial audio clocks and data
`timescale 1ns/1ps
module sai_host_model
	import sai_pkg::*;
(
	// serial link
	output logic bit_clock,
	output logic word_select_frame_sync,
	output logic serial_data_input
);
	initial begin
		bit_clock = 1'b0;
		word_select_frame_sync = 1'b0;
		serial_data_input = 1'b0;
	end
	// clocks stand still between calls, which the port sees as a halt once the gap reaches HALT_CYC system clocks
	task automatic stream(input logic [1:0] fmt, input int wl, half, ofs, n,
			input logic [31:0] l, r);
		int          k;
		logic [31:0] w;
		#13;
		repeat (n) begin
			for (int j = 0; j < 2 * half; j++) begin
				w = (j < half) ? l : r;
				k = j % half;
				if (fmt == SAI_FMT_I2S)
					k = k - 1;
				if (fmt == SAI_FMT_RIGHT_JUSTIFIED)
					k = k - (half - wl);
				if (fmt == SAI_FMT_TDM) begin
					k = j - ofs;
					w = l;
					if (k >= wl) begin
						k = k - wl;
						w = r;
					end
				end
				word_select_frame_sync = (fmt == SAI_FMT_TDM) ? (j == 0) :
					((fmt == SAI_FMT_I2S) == (j >= half));
				// unused bits toggle so a stale level never looks like data
				serial_data_input = (k >= 0 && k < wl) ? w[wl-1-k] : ~serial_data_input;
				#400 bit_clock = 1'b1;
				#400 bit_clock = 1'b0;
			end
		end
	endtask
endmodule

//--- verif/sai_port_chk.sv
// assertion checker for the serial audio input port
`timescale 1ns/1ps
module sai_port_chk
	import sai_pkg::*;
#(
	parameter int HALT_CYC = SAI_HALT_CYC
) (
	// clock, reset, link
	input wire logic                 clk_sys,
	input wire logic                 rstn,
	input wire logic                 bit_clock,
	// registers
	input wire logic [7:0]           reg_addr,
	input wire logic [7:0]           reg_wdata,
	input wire logic                 reg_wr,
	input wire logic [7:0]           reg_rdata,
	// outputs
	input wire sai_pkg::sai_sample_s sample,
	input wire logic                 sample_valid,
	input wire logic                 dsp_clk_en,
	input wire logic                 out_enable
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// margin over the detect time covers the two-flop synchroniser
	logic        bc_q;
	int unsigned still;
	always_ff @(posedge clk_sys) begin
		bc_q <= bit_clock;
		if (!rstn || bc_q != bit_clock)
			still <= 0;
		else if (still < HALT_CYC + 8)
			still <= still + 1;
	end
	wire stopped = (still == HALT_CYC + 8);
	sequence s_wr(a);
		reg_wr && reg_addr == a ##1 !reg_wr && reg_addr == a;
	endsequence
	property p_fmt_rw;
		s_wr(SAI_ADDR_FORMAT) |-> reg_rdata == $past(reg_wdata);
	endproperty
	property p_ofs_rw;
		s_wr(SAI_ADDR_OFFSET) |-> reg_rdata == $past(reg_wdata);
	endproperty
	property p_halt_flag;
		stopped && reg_addr == SAI_ADDR_STATUS |-> reg_rdata[SAI_ST_HALT];
	endproperty
	property p_halt_hiz;
		stopped |-> !out_enable;
	endproperty
	property p_valid_gap;
		sample_valid |=> !sample_valid [*8];
	endproperty
	property p_valid_run;
		sample_valid |-> out_enable;
	endproperty
	property p_hold;
		$changed(sample.right) |-> sample_valid;
	endproperty
	property p_dsp_run;
		dsp_clk_en |-> out_enable;
	endproperty
	a_fmt_rw: assert property (p_fmt_rw) else $error("format readback");
	a_ofs_rw: assert property (p_ofs_rw) else $error("offset readback");
	a_halt_flag: assert property (p_halt_flag) else $error("halt flag");
	a_halt_hiz: assert property (p_halt_hiz) else $error("no hi-z");
	a_valid_gap: assert property (p_valid_gap) else $error("valid burst");
	a_valid_run: assert property (p_valid_run) else $error("valid idle");
	a_hold: assert property (p_hold) else $error("sample moved");
	a_dsp_run: assert property (p_dsp_run) else $error("dsp clock idle");
endmodule
bind sai_port sai_port_chk #(.HALT_CYC(HALT_CYC)) u_chk (.clk_sys(clk_sys), .rstn(rstn),
	.bit_clock(bit_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rdata(reg_rdata), .sample(sample), .sample_valid(sample_valid),
	.dsp_clk_en(dsp_clk_en), .out_enable(out_enable));

//--- verif/sai_port_tb.sv
// self-checking bench for the serial audio input port
`timescale 1ns/1ps
module sai_port_tb;
	import sai_pkg::*;
	logic        clk_sys, rstn, reg_wr, sample_valid, dsp_clk_en, out_enable;
	logic        bit_clock, word_select_frame_sync, serial_data_input;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	sai_sample_s sample;
	sai_clkcfg_s clk_cfg;
	int          err_total, total_checks, cyc;
	sai_port #(.HALT_CYC(100)) uut (.clk_sys(clk_sys), .rstn(rstn), .bit_clock(bit_clock),
		.word_select_frame_sync(word_select_frame_sync), .serial_data_input(serial_data_input),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
		.sample(sample), .sample_valid(sample_valid), .clk_cfg(clk_cfg),
		.dsp_clk_en(dsp_clk_en), .out_enable(out_enable));
	sai_host_model host (.bit_clock(bit_clock),
		.word_select_frame_sync(word_select_frame_sync), .serial_data_input(serial_data_input));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic chkrd(input logic [7:0] a, e);
		@(negedge clk_sys);
		reg_addr = a;
		#1 chk(reg_rdata === e, "register read");
	endtask
	task automatic play(input logic [1:0] fmt, wc, input int wl, half, ofs,
			input logic [31:0] l, r);
		logic [7:0] f;
		f = {ofs[9:8], fmt, (fmt == SAI_FMT_TDM) ? 2'b01 : 2'b00, wc};
		wr(SAI_ADDR_FORMAT, f);
		wr(SAI_ADDR_OFFSET, ofs[7:0]);
		chkrd(SAI_ADDR_FORMAT, f);
		host.stream(fmt, wl, half, ofs, 4, l, r);
		repeat (10) @(negedge clk_sys);
		chk(out_enable === 1'b1, "outputs not enabled");
		chk(sample.left === l << (32 - wl), "left word");
		chk(sample.right === r << (32 - wl), "right word");
	endtask
	task automatic t_reset;
		chkrd(SAI_ADDR_FORMAT, SAI_FORMAT_RST);
		chkrd(SAI_ADDR_OFFSET, SAI_OFFSET_RST);
		chkrd(8'h00, 8'h00);
		chk(out_enable === 1'b0, "enabled without clocks");
		wr(SAI_ADDR_FORMAT, 8'hC2);
		chkrd(SAI_ADDR_FORMAT, 8'hC2);
	endtask
	task automatic t_i2s;
		play(SAI_FMT_I2S, SAI_WL_24, 24, 32, 0, 32'h0080_0001, 32'h007F_FFFE);
		chk(clk_cfg.lock === 1'b1, "not locked");
		chk(clk_cfg.rate === SAI_RATE_32, "rate family");
	endtask
	task automatic t_halt;
		@(negedge clk_sys);
		reg_addr = SAI_ADDR_STATUS;
		repeat (150) @(negedge clk_sys);
		chk(out_enable === 1'b0, "no hi-z on halt");
		chk(reg_rdata[SAI_ST_HALT] === 1'b1, "halt not flagged");
		// 48 bit clocks per frame is not a supported ratio
		host.stream(SAI_FMT_I2S, 24, 24, 0, 3, 32'h0012_3456, 32'h0065_4321);
		@(negedge clk_sys);
		#1 chk(reg_rdata[SAI_ST_RATIO] === 1'b1, "bad ratio not flagged");
		chk(out_enable === 1'b0, "enabled on bad ratio");
		play(SAI_FMT_I2S, SAI_WL_24, 24, 32, 0, 32'h00A5_5A5A, 32'h005A_A5A5);
	endtask
	task automatic t_formats;
		play(SAI_FMT_LEFT_JUSTIFIED, SAI_WL_16, 16, 32, 0,
			32'h0000_8001, 32'h0000_7FFE);
		play(SAI_FMT_RIGHT_JUSTIFIED, SAI_WL_20, 20, 32, 0,
			32'h000C_3A5F, 32'h0003_C5A0);
		play(SAI_FMT_TDM, SAI_WL_32, 32, 64, 61, 32'hC001_D00D, 32'h1234_5678);
		play(SAI_FMT_TDM, SAI_WL_32, 32, 64, 5, 32'h8765_4321, 32'h0F0F_F0F0);
	endtask
	initial begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		err_total = 0;
		total_checks = 0;
		cyc = 0;
		repeat (10) @(negedge clk_sys);
		rstn = 1'b1;
		t_reset();
		t_i2s();
		t_halt();
		t_formats();
		report_and_stop();
	end
endmodule
